// [src/rpc_top.sv]
/*
 * Receive-side sideband logic: drives the packet compression output toward an external
 * repeater management controller and qualifies the active-low packet reject input.
 * Assumes the bit clocks, carrier sense and reject arrive as pins from outside the mclk domain,
 * that the receive deserializer pulses frameStart in mclk when the first bit after the start
 * delimiter is due, and that addrMatch is settled by the time the destination address is in.
 */
`timescale 1ns/1ns
`include "rpc_defs.svh"

// Behaviour
// RULE1 - The compression output asserts on an address table match or on a mismatch, as two config bits select.
// RULE2 - The compression output stays undriven from reset until software writes the selection bits.
// RULE3 - With the condition met, the output asserts right after the fourth bit of the seventh frame byte.
// RULE4 - The output deasserts one transmit bit clock after carrier sense falls at frame end.
// RULE5 - Outside logic holds reject low at least two receive bit clocks and the frame is then rejected.
// RULE6 - Outside logic may assert reject up to the second-to-last bit and the rejection still works.
// RULE7 - Reject is sampled on receive bit clock edges and consecutive low samples are counted.
module rpc_top (
    input wire logic mclk,
    input wire logic rst,
    input rpc_pkg::rpc_pins_s pins,
    input wire logic frameStart,
    input wire logic addrMatch,
    input wire logic cfgWrite,
    input wire logic [`RPC_CFG_WIDTH-1:0] cfgData,
    output rpc_pkg::rpc_compress_s packet_compress_out,
    output logic frameReject,
    output logic rejectPulse,
    output rpc_pkg::rpc_mode_e compressMode
);
    import rpc_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic rxLevel;
    logic rxRise;
    logic rxFall;
    logic txLevel;
    logic txRise;
    logic txFall;
    logic crsLevel;
    logic crsRise;
    logic crsFall;
    logic rejLevelN;
    logic rejRise;
    logic rejFall;

    rpc_pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sync_rx (
        .mclk(mclk),
        .rst(rst),
        .pinAsync(pins.rxBitClock),
        .level(rxLevel),
        .rise(rxRise),
        .fall(rxFall)
    );

    rpc_pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sync_tx (
        .mclk(mclk),
        .rst(rst),
        .pinAsync(pins.txBitClock),
        .level(txLevel),
        .rise(txRise),
        .fall(txFall)
    );

    rpc_pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sync_crs (
        .mclk(mclk),
        .rst(rst),
        .pinAsync(pins.carrierSense),
        .level(crsLevel),
        .rise(crsRise),
        .fall(crsFall)
    );

    // Reject idles high, so its synchroniser resets high to avoid a false low sample.
    rpc_pin_sync #(
        .RESET_LEVEL(1'b1)
    ) u_sync_rej (
        .mclk(mclk),
        .rst(rst),
        .pinAsync(pins.packetRejectInN),
        .level(rejLevelN),
        .rise(rejRise),
        .fall(rejFall)
    );

    // ****************************************************************
    // Block state
    // ****************************************************************
    localparam logic [`RPC_BIT_COUNT_WIDTH-1:0] TRIGGER_COUNT = `RPC_BIT_COUNT_WIDTH'(`RPC_TRIGGER_COUNT);
    localparam logic [`RPC_LOW_COUNT_WIDTH-1:0] REJECT_MIN_LOW = `RPC_LOW_COUNT_WIDTH'(`RPC_REJECT_MIN_LOW);

    rpc_top_s state_reg;
    rpc_top_s state_next;
    logic conditionMet;

    // The table verdict is read only at the trigger bit, so it may still settle before then.
    always_comb begin
        unique case (state_reg.mode)
            RPC_MODE_MATCH: begin
                conditionMet = addrMatch; // [RULE1]
            end
            RPC_MODE_MISS: begin
                conditionMet = ~addrMatch; // [RULE1]
            end
            RPC_MODE_OFF,
            RPC_MODE_RSVD: begin
                conditionMet = 1'b0;
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.rejectPulse = 1'b0;

        if (cfgWrite) begin
            state_next.configured = 1'b1; // [RULE2]
            state_next.mode = rpc_mode_e'(cfgData[`RPC_CFG_MODE_MSB:`RPC_CFG_MODE_LSB]); // [RULE1]
        end

        // ****************************************************************
        // Compression sequencing
        // ****************************************************************
        unique case (state_reg.state)
            RPC_ST_IDLE: begin
                if (frameStart) begin
                    state_next.bitCount = '0;
                    state_next.state = RPC_ST_COUNT;
                end
            end
            RPC_ST_COUNT: begin
                // Carrier dropping before the trigger bit abandons the count with the output untouched.
                if (crsFall) begin
                    state_next.state = RPC_ST_IDLE;
                end else if (rxRise) begin
                    state_next.bitCount = state_reg.bitCount + `RPC_BIT_COUNT_WIDTH'(1);
                    if (state_reg.bitCount + `RPC_BIT_COUNT_WIDTH'(1) == TRIGGER_COUNT) begin
                        // An unmet condition or a disabled mode ends the count; the output stays low for this frame.
                        if (conditionMet) begin
                            state_next.compressOut = 1'b1; // [RULE3]
                            state_next.state = RPC_ST_ASSERTED;
                        end else begin
                            state_next.state = RPC_ST_IDLE;
                        end
                    end
                end
            end
            RPC_ST_ASSERTED: begin
                if (crsFall) begin
                    state_next.state = RPC_ST_DRAIN; // [RULE4]
                end
            end
            RPC_ST_DRAIN: begin
                // The transmit clock runs free; were it stopped, the output would stay high here.
                if (txRise) begin
                    state_next.compressOut = 1'b0; // [RULE4]
                    state_next.state = RPC_ST_IDLE;
                end
            end
        endcase

        // ****************************************************************
        // Reject qualification
        // ****************************************************************
        // A new carrier clears the previous frame's verdict; a set in the same cycle still wins below.
        if (crsRise) begin
            state_next.rejectLatched = 1'b0;
            state_next.lowCount = '0;
        end
        // Samples after carrier falls are ignored, so a request on the last bit alone never counts.
        if (rxRise && (crsLevel || crsRise)) begin
            if (!rejLevelN) begin
                if (state_reg.lowCount != REJECT_MIN_LOW) begin
                    state_next.lowCount = state_reg.lowCount + `RPC_LOW_COUNT_WIDTH'(1); // [RULE7]
                end
                // Counting runs to the last sampled bit, so a late request still lands. [RULE6]
                if (state_reg.lowCount + `RPC_LOW_COUNT_WIDTH'(1) >= REJECT_MIN_LOW && !state_reg.rejectLatched) begin
                    state_next.rejectLatched = 1'b1; // [RULE5]
                    state_next.rejectPulse = 1'b1; // [RULE5]
                end
            end else begin
                state_next.lowCount = '0; // [RULE7]
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg.configured <= 1'b0;
            state_reg.mode <= rpc_mode_e'(`RPC_MODE_RESET);
            state_reg.state <= RPC_ST_IDLE;
            state_reg.bitCount <= '0;
            state_reg.lowCount <= '0;
            state_reg.compressOut <= 1'b0;
            state_reg.rejectLatched <= 1'b0;
            state_reg.rejectPulse <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The pin floats until configured, so a repeater sharing the line sees no stray level. [RULE2]
    assign packet_compress_out.oe = state_reg.configured;
    assign packet_compress_out.value = state_reg.compressOut;
    assign frameReject = state_reg.rejectLatched;
    assign rejectPulse = state_reg.rejectPulse;
    // The mode is exported so the far side can tell an idle mode from an unmet condition.
    assign compressMode = state_reg.mode;

endmodule : rpc_top

// [src/rpc_defs.svh]
/*
 * Constants of the receive compression and reject sideband block: configuration field positions,
 * reset values and bit-position counts.
 * Assumes it is included by bare name by the package and by the design modules.
 */
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH

// ****************************************************************
// Configuration field layout
// ****************************************************************
`define RPC_CFG_WIDTH 16
`define RPC_CFG_MODE_LSB 1
`define RPC_CFG_MODE_MSB 2
`define RPC_MODE_RESET 2'h0

// ****************************************************************
// Frame bit positions
// ****************************************************************
`define RPC_BITS_PER_BYTE 8
`define RPC_TRIGGER_BYTE 7
`define RPC_TRIGGER_BIT 4
`define RPC_TRIGGER_COUNT (((`RPC_TRIGGER_BYTE) - 1) * (`RPC_BITS_PER_BYTE) + (`RPC_TRIGGER_BIT))
`define RPC_BIT_COUNT_WIDTH 7

// ****************************************************************
// Reject qualification
// ****************************************************************
`define RPC_REJECT_MIN_LOW 2
`define RPC_LOW_COUNT_WIDTH 2

`endif

// [src/rpc_pkg.sv]
/*
 * Types of the receive compression and reject sideband block.
 * Assumes rpc_defs.svh is on the include path.
 */
`include "rpc_defs.svh"

package rpc_pkg;

    // ****************************************************************
    // Modes and states
    // ****************************************************************
    typedef enum logic [1:0] {
        RPC_MODE_OFF = 2'b00,
        RPC_MODE_MATCH = 2'b01,
        RPC_MODE_MISS = 2'b10,
        RPC_MODE_RSVD = 2'b11
    } rpc_mode_e;

    typedef enum logic [1:0] {
        RPC_ST_IDLE = 2'b00,
        RPC_ST_COUNT = 2'b01,
        RPC_ST_ASSERTED = 2'b10,
        RPC_ST_DRAIN = 2'b11
    } rpc_state_e;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic rxBitClock;
        logic txBitClock;
        logic carrierSense;
        logic packetRejectInN;
    } rpc_pins_s;

    typedef struct packed {
        logic value;
        logic oe;
    } rpc_compress_s;

    typedef struct packed {
        logic stage1;
        logic stage2;
        logic stage3;
    } rpc_sync_s;

    typedef struct packed {
        logic configured;
        rpc_mode_e mode;
        rpc_state_e state;
        logic [`RPC_BIT_COUNT_WIDTH-1:0] bitCount;
        logic [`RPC_LOW_COUNT_WIDTH-1:0] lowCount;
        logic compressOut;
        logic rejectLatched;
        logic rejectPulse;
    } rpc_top_s;

endpackage : rpc_pkg

// [src/rpc_pin_sync.sv]
/*
 * Two-flop synchroniser for one pin, with rise and fall pulses taken behind the second flop.
 * Assumes the pin toggles no faster than a quarter of mclk.
 */
`timescale 1ns/1ns
`include "rpc_defs.svh"

module rpc_pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pinAsync,
    output logic level,
    output logic rise,
    output logic fall
);
    import rpc_pkg::*;

    rpc_sync_s state_reg;
    rpc_sync_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage1 = pinAsync;
        state_next.stage2 = state_reg.stage1;
        state_next.stage3 = state_reg.stage2;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
        end else begin
            state_reg <= state_next;
        end
    end

    // Edges compare the second and third flops only, so the metastable first flop feeds nothing else.
    assign level = state_reg.stage2;
    assign rise = state_reg.stage2 & ~state_reg.stage3;
    assign fall = ~state_reg.stage2 & state_reg.stage3;

endmodule : rpc_pin_sync

// [verification/rpc_top_monitor.sv]
/*
 * Checker for rpc_top: compression output enable, mode load, mode at assertion, release timing, reject flag.
 * Assumes it is bound to rpc_top and sees only its ports.
 */
`timescale 1ns/1ns
`include "rpc_defs.svh"

module rpc_top_monitor (
    input wire logic mclk,
    input wire logic rst,
    input rpc_pkg::rpc_pins_s pins,
    input wire logic cfgWrite,
    input wire logic [`RPC_CFG_WIDTH-1:0] cfgData,
    input rpc_pkg::rpc_compress_s packet_compress_out,
    input wire logic frameReject,
    input wire logic rejectPulse,
    input rpc_pkg::rpc_mode_e compressMode
);
    import rpc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // Properties
    // ****************************************************************
    chk_hiz_reset: assert property (disable iff (1'b0) rst |=> !packet_compress_out.oe)
        else $error("enable high after reset");
    chk_hiz_hold: assert property (!packet_compress_out.oe && !cfgWrite |=> !packet_compress_out.oe)
        else $error("enable rose without a write");
    chk_oe_release: assert property (cfgWrite |=> packet_compress_out.oe)
        else $error("enable low after a write");
    chk_mode_load: assert property (cfgWrite |=> compressMode == $past(cfgData[2:1]))
        else $error("mode not loaded");
    chk_assert_mode: assert property ($rose(packet_compress_out.value) |->
        compressMode inside {RPC_MODE_MATCH, RPC_MODE_MISS})
        else $error("output asserted in an idle mode");
    chk_drop_after: assert property ($fell(packet_compress_out.value) |-> !$past(pins.carrierSense, 4))
        else $error("output released before carrier fell");
    chk_drop_bound: assert property ($fell(pins.carrierSense) && packet_compress_out.value |->
        ##[4:16] !packet_compress_out.value)
        else $error("output not released in time");
    chk_pulse_single: assert property (rejectPulse |=> !rejectPulse)
        else $error("reject pulse too long");
    chk_pulse_flag: assert property (rejectPulse |-> frameReject && !$past(frameReject))
        else $error("reject pulse without flag rise");
    chk_flag_hold: assert property (frameReject && !pins.carrierSense |=> frameReject)
        else $error("reject flag dropped without carrier");
endmodule : rpc_top_monitor

bind rpc_top rpc_top_monitor i_mon (.mclk(mclk), .rst(rst), .pins(pins), .cfgWrite(cfgWrite), .cfgData(cfgData),
    .packet_compress_out(packet_compress_out), .frameReject(frameReject), .rejectPulse(rejectPulse),
    .compressMode(compressMode));

// [verification/rpc_far_model.sv]
/*
 * Far-side model: receive bit clock and carrier per frame, free transmit clock, reject requests.
 * Assumes mclk at 20 MHz; bit clocks run at mclk/8 so the block can see every edge.
 */
`timescale 1ns/1ns

module rpc_far_model (
    input wire logic mclk,
    output rpc_pkg::rpc_pins_s pins,
    output logic frameStart,
    output int bitNum
);
    import rpc_pkg::*;
    logic [2:0] txDiv = 3'h0;
    initial begin
        pins = 4'h1;
        frameStart = 1'b0;
        bitNum = 0;
    end
    always @(posedge mclk) begin
        txDiv <= txDiv + 3'h1;
        pins.txBitClock <= txDiv[2];
    end

    // ****************************************************************
    // Frame
    // ****************************************************************
    // The receive clock stands still low between frames.
    task automatic send(input int nb, input int rs, input int rl);
        @(posedge mclk) frameStart <= 1'b1;
        pins.carrierSense <= 1'b1;
        bitNum <= 0;
        @(posedge mclk) frameStart <= 1'b0;
        for (int i = 1; i <= nb; i++) begin
            pins.rxBitClock <= 1'b0;
            pins.packetRejectInN <= !(i >= rs && i < rs + rl);
            repeat (4) @(posedge mclk);
            pins.rxBitClock <= 1'b1;
            bitNum <= i;
            repeat (4) @(posedge mclk);
        end
        pins.rxBitClock <= 1'b0;
        pins.packetRejectInN <= 1'b1;
        pins.carrierSense <= 1'b0;
        repeat (30) @(posedge mclk);
    endtask : send
endmodule : rpc_far_model

// [verification/rpc_top_test.sv]
/*
 * Self-checking bench for rpc_top: high-Z until configured, all modes, reject qualification.
 * Assumes the far-side model and the bound checker are compiled with it.
 */
`timescale 1ns/1ns

module rpc_top_test;
    import rpc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic addrMatch = 1'b0;
    logic cfgWrite = 1'b0;
    logic [15:0] cfgData = 16'h0000;
    logic frameStart;
    rpc_pins_s pins;
    rpc_compress_s pco;
    logic frameReject;
    logic rejectPulse;
    rpc_mode_e compressMode;
    int bitNum;
    int errTotal = 0;
    int checkCount = 0;
    int riseBit = -1;
    int pulseCount = 0;

    rpc_far_model i_far (.mclk(mclk), .pins(pins), .frameStart(frameStart), .bitNum(bitNum));
    rpc_top i_dut (.mclk(mclk), .rst(rst), .pins(pins), .frameStart(frameStart), .addrMatch(addrMatch),
        .cfgWrite(cfgWrite), .cfgData(cfgData), .packet_compress_out(pco), .frameReject(frameReject),
        .rejectPulse(rejectPulse), .compressMode(compressMode));

    initial forever #25 mclk = !mclk;
    always @(posedge mclk) begin
        if (rejectPulse === 1'b1) pulseCount++;
        if (pco.value === 1'b1 && riseBit < 0) riseBit = bitNum;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (exp !== got) begin
            errTotal++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    task automatic stopTest;
        $display("checks %0d errors %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stopTest

    task automatic t_hiz;
        addrMatch <= 1'b1;
        i_far.send(64, 0, 0);
        check("oe", 0, pco.oe);
    endtask : t_hiz

    task automatic t_compress(input logic [1:0] m, input logic match);
        @(posedge mclk) cfgWrite <= 1'b1;
        cfgData <= 16'({m, 1'b0});
        addrMatch <= match;
        @(posedge mclk) cfgWrite <= 1'b0;
        @(negedge mclk) check("oe", 1, pco.oe);
        check("mode", 32'(m), 32'(compressMode));
        riseBit = -1;
        i_far.send(64, 0, 0);
        check("rise bit", ((m == 2'h1 && match) || (m == 2'h2 && !match)) ? 52 : -1, riseBit);
        check("value", 0, pco.value);
    endtask : t_compress

    task automatic t_reject(input int rs, input int rl, input logic exp);
        pulseCount = 0;
        i_far.send(64, rs, rl);
        check("reject", 32'(exp), 32'(frameReject));
        check("pulses", 32'(exp), pulseCount);
    endtask : t_reject

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_hiz();
        for (int k = 0; k < 8; k++) t_compress(k[2:1], k[0]);
        t_reject(10, 1, 1'b0);
        t_reject(63, 2, 1'b1);
        t_reject(20, 1, 1'b0);
        t_reject(5, 6, 1'b1);
        stopTest();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        stopTest();
    end
endmodule : rpc_top_test
